//--- logic/pme_defs.vh
// Constants for the programming mode entry block
`ifndef PME_DEFS_VH
`define PME_DEFS_VH

// ****************************************************
// Opcode and timing
// ****************************************************
`define PME_OPCODE_W 10
`define PME_ENTRY_OPCODE 10'h34B
`define PME_CLK_HZ 25000000
`define PME_RESET_TIME_US 3700
// Reset sequence length in mclk cycles, longest time rounded down
`define PME_RESET_CYCLES ((`PME_RESET_TIME_US * (`PME_CLK_HZ / 1000000)))
`define PME_CNT_W 20

// ****************************************************
// APB register map (byte addresses)
// ****************************************************
`define PME_ADDR_W 8
`define PME_REG_STATUS 8'h00
`define PME_REG_CONTROL 8'h04
`define PME_REG_INIT1 8'h08
`define PME_REG_INIT2 8'h0C
`define PME_REG_FLAGS 8'h10

// Field positions
`define PME_ST_PROG_MODE 0
`define PME_ST_PROG_FLAG 1
`define PME_ST_IN_RESET 2
`define PME_ST_NORMAL 3
`define PME_ST_FULL_ACCESS 4
`define PME_CTL_ERASE 0
`define PME_CTL_PROG_ONLY 1
`define PME_INIT1_RD 0
`define PME_INIT1_WR 1
`define PME_FLAGS_GIM 7

// Reset values
`define PME_INIT2_FACTORY 8'h80
`define PME_INIT1_RESET 8'h00
`define PME_FLAGS_RESET 8'h00

`endif

//--- logic/pme_sync.v
// Two flip-flop synchroniser for one pin level
`timescale 1ns/1ns
module pme_sync (
    input wire mclk,
    input wire arst_n,
    input wire async_in,
    output reg sync_out
);
    reg stage1;

    // First stage feeds only the second, to contain metastability
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // pme_sync

//--- logic/pme_opcode_shift.v
// Opcode shift register and pattern match for the programming entry
`timescale 1ns/1ns
`include "pme_defs.vh"
module pme_opcode_shift (
    input wire mclk,
    input wire arst_n,
    input wire clear,
    input wire shift_en,
    input wire bit_in,
    output reg match
);
    reg [`PME_OPCODE_W-1:0] shreg;
    wire [`PME_OPCODE_W-1:0] next_shreg;

    // MSB arrives first, so new bits enter at the bottom
    assign next_shreg = {shreg[`PME_OPCODE_W-2:0], bit_in};

    // Cleared at each reset start so stale bits cannot match
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            shreg <= {`PME_OPCODE_W{1'b0}};
            match <= 1'b0;
        end else if (clear) begin
            shreg <= {`PME_OPCODE_W{1'b0}};
            match <= 1'b0;
        end else if (shift_en) begin
            shreg <= next_shreg;
            match <= (next_shreg == `PME_ENTRY_OPCODE);
        end else begin
            match <= 1'b0;
        end
    end
endmodule // pme_opcode_shift

//--- logic/pme_top.v
// Programming mode entry: reset sequencing, opcode detect, protection and APB
// Notes on behaviour
// - Programming mode is requested only by a 10-bit opcode during reset.
// - Opcode arrives MSB first, one bit per rising edge of link clock.
// - After each bit, last ten bits compared to entry pattern; match sets flag.
// - Flag is held; programming mode entered only when reset sequence ends.
// - Without a match, normal operation starts when reset sequence ends.
// - System reset starts from power-on or low pulse on the reset pin.
// - Every system reset reloads the oscillator trim shadow with factory value.
// - With protection on, init registers refused until full erase; it clears code and init one.
// - After erase, full access for the session, even if protect bits set again.
// - Programming-only init registers are unreachable in normal mode.
// - Core flags are read-only except the global interrupt mask bit.
// - Each non-volatile init register has its own volatile shadow.
// - Programming mode gives access to all memories via the four-wire link; here the link only carries the entry opcode, access is over APB.
// - Programming mode left only on power-down or external reset.
// - Link has load, serial in, serial out and clock pins.
`timescale 1ns/1ns
`include "pme_defs.vh"
module pme_top #(
    parameter RESET_CYCLES = `PME_RESET_CYCLES
) (
    input wire mclk,
    input wire arst_n,
    input wire por_n,
    input wire reset_pin_n,
    input wire link_clock,
    input wire link_load,
    input wire serial_in,
    output reg serial_out,
    output wire serial_out_oe_n,
    input wire [7:0] nv_init1,
    input wire [7:0] nv_init2,
    input wire core_flags_wr,
    input wire [7:0] core_flags_wdata,
    input wire [6:0] core_flags_hw,
    output reg prog_mode,
    output reg normal_run,
    output reg erase_pulse,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PME_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr
);
    // ****************************************************
    // Pin synchronisers
    // ****************************************************
    wire por_s;
    wire rpin_s;
    wire lclk_s;
    wire sin_s;
    wire load_s;

    pme_sync u_sync_por (.mclk(mclk), .arst_n(arst_n), .async_in(por_n), .sync_out(por_s));
    pme_sync u_sync_rst (.mclk(mclk), .arst_n(arst_n), .async_in(reset_pin_n),
        .sync_out(rpin_s));
    pme_sync u_sync_clk (.mclk(mclk), .arst_n(arst_n), .async_in(link_clock),
        .sync_out(lclk_s));
    pme_sync u_sync_sin (.mclk(mclk), .arst_n(arst_n), .async_in(serial_in),
        .sync_out(sin_s));
    pme_sync u_sync_ld (.mclk(mclk), .arst_n(arst_n), .async_in(link_load),
        .sync_out(load_s));

    // ****************************************************
    // Reset sequencer
    // ****************************************************
    localparam ST_HOLD = 2'd0;
    localparam ST_SEQ = 2'd1;
    localparam ST_NORMAL = 2'd2;
    localparam ST_PROG = 2'd3;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [`PME_CNT_W-1:0] seq_cnt;
    reg lclk_d;
    reg prog_flag;
    wire hold_reset;
    wire seq_start;
    wire link_rise;
    wire opcode_match;
    wire seq_done;

    // Either source holds the device in reset while low
    assign hold_reset = !por_s || !rpin_s;
    assign seq_start = (state == ST_HOLD) && !hold_reset;
    assign link_rise = lclk_s && !lclk_d;
    assign seq_done = (seq_cnt == RESET_CYCLES[`PME_CNT_W-1:0] - 1'b1);

    // Link clock is sampled, so edges closer than a few mclk are lost
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lclk_d <= 1'b0;
        end else begin
            lclk_d <= lclk_s;
        end
    end

    // Bits count only during the sequence; before or after they are ignored
    pme_opcode_shift u_shift (
        .mclk(mclk),
        .arst_n(arst_n),
        .clear(state == ST_HOLD),
        .shift_en(link_rise && (state == ST_SEQ)),
        .bit_in(sin_s),
        .match(opcode_match)
    );

    // State transitions
    always @* begin
        next_state = state;
        case (state)
            ST_HOLD: begin
                if (!hold_reset) begin
                    next_state = ST_SEQ;
                end
            end
            ST_SEQ: begin
                if (hold_reset) begin
                    next_state = ST_HOLD;
                end else if (seq_done) begin
                    next_state = (prog_flag || opcode_match) ? ST_PROG : ST_NORMAL;
                end
            end
            ST_NORMAL: begin
                if (hold_reset) begin
                    next_state = ST_HOLD;
                end
            end
            ST_PROG: begin
                if (hold_reset) begin
                    next_state = ST_HOLD;
                end
            end
            default: begin
                next_state = ST_HOLD;
            end
        endcase
    end

    // Sequence counter and held program-mode flag
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_HOLD;
            seq_cnt <= {`PME_CNT_W{1'b0}};
            prog_flag <= 1'b0;
        end else begin
            state <= next_state;
            if (state != ST_SEQ) begin
                seq_cnt <= {`PME_CNT_W{1'b0}};
            end else begin
                seq_cnt <= seq_cnt + 1'b1;
            end
            if (state == ST_HOLD) begin
                prog_flag <= 1'b0;
            end else if (opcode_match) begin
                prog_flag <= 1'b1;
            end
        end
    end

    // Mode outputs
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prog_mode <= 1'b0;
            normal_run <= 1'b0;
        end else begin
            prog_mode <= (next_state == ST_PROG);
            normal_run <= (next_state == ST_NORMAL);
        end
    end

    // ****************************************************
    // Shadows, protection and core flags
    // ****************************************************
    reg [7:0] init1_shadow;
    reg [7:0] init2_shadow;
    reg [7:0] core_flags_reg;
    reg full_access;
    reg prog_only_en;
    wire prot_on;
    wire wr_fire;
    wire rd_fire;
    wire prog_only_addr;
    wire erase_req;

    assign prot_on = init1_shadow[`PME_INIT1_RD] || init1_shadow[`PME_INIT1_WR];
    assign wr_fire = psel && penable && pwrite;
    assign rd_fire = psel && penable && !pwrite;
    assign prog_only_addr = (paddr == `PME_REG_INIT1) || (paddr == `PME_REG_INIT2);
    assign erase_req = wr_fire && (paddr == `PME_REG_CONTROL) && pwdata[`PME_CTL_ERASE]
        && prog_mode;

    // Shadows reload on every reset; one shadow per non-volatile register
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            init1_shadow <= `PME_INIT1_RESET;
            init2_shadow <= `PME_INIT2_FACTORY;
            full_access <= 1'b0;
            erase_pulse <= 1'b0;
            prog_only_en <= 1'b1;
        end else begin
            erase_pulse <= erase_req;
            if (state == ST_HOLD) begin
                init1_shadow <= nv_init1;
                init2_shadow <= `PME_INIT2_FACTORY;
                full_access <= 1'b0;
                // Gate restored each reset so normal mode never starts unguarded
                prog_only_en <= 1'b1;
            end else if (erase_req) begin
                init1_shadow <= `PME_INIT1_RESET;
                full_access <= 1'b1;
            end else if (wr_fire && prog_mode && (!prot_on || full_access)) begin
                if (paddr == `PME_REG_INIT1) begin
                    init1_shadow <= pwdata[7:0];
                end
                if (paddr == `PME_REG_INIT2) begin
                    init2_shadow <= pwdata[7:0];
                end
            end
            if (wr_fire && prog_mode && (paddr == `PME_REG_CONTROL)) begin
                prog_only_en <= pwdata[`PME_CTL_PROG_ONLY];
            end
        end
    end

    // Core flags: hardware sets the low bits, software may write only the mask
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            core_flags_reg <= `PME_FLAGS_RESET;
        end else begin
            core_flags_reg[6:0] <= core_flags_hw;
            if (core_flags_wr) begin
                core_flags_reg[`PME_FLAGS_GIM] <= core_flags_wdata[`PME_FLAGS_GIM];
            end else if (wr_fire && (paddr == `PME_REG_FLAGS)) begin
                core_flags_reg[`PME_FLAGS_GIM] <= pwdata[`PME_FLAGS_GIM];
            end
        end
    end

    // ****************************************************
    // APB slave: zero wait, error on unmapped or blocked access
    // ****************************************************
    reg addr_ok;
    reg blocked;

    assign pready = 1'b1;
    assign pslverr = psel && penable && (!addr_ok || blocked);

    // Decode; protected devices refuse the init registers until full access
    always @* begin
        addr_ok = (paddr == `PME_REG_STATUS) || (paddr == `PME_REG_CONTROL)
            || (paddr == `PME_REG_INIT1) || (paddr == `PME_REG_INIT2)
            || (paddr == `PME_REG_FLAGS);
        blocked = prog_only_addr && prog_only_en && !prog_mode;
        if (prog_mode && prot_on && !full_access && prog_only_addr) begin
            blocked = 1'b1;
        end
    end

    // Read data registered at the setup phase
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `PME_REG_STATUS: begin
                    prdata <= {27'h000_0000, full_access, normal_run,
                        (state == ST_SEQ) || (state == ST_HOLD), prog_flag, prog_mode};
                end
                `PME_REG_CONTROL: begin
                    prdata <= {30'h0000_0000, prog_only_en, 1'b0};
                end
                `PME_REG_INIT1: begin
                    prdata <= {24'h00_0000, init1_shadow};
                end
                `PME_REG_INIT2: begin
                    prdata <= {24'h00_0000, init2_shadow};
                end
                `PME_REG_FLAGS: begin
                    prdata <= {24'h00_0000, core_flags_reg};
                end
                default: begin
                    prdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ****************************************************
    // Serial output: echoes status during programming, released otherwise
    // ****************************************************
    assign serial_out_oe_n = !prog_mode;

    // Word protocol is out of scope; line shows ready high when driven, but goes low during erase_pulse while load is low
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            serial_out <= 1'b0;
        end else begin
            serial_out <= prog_mode && (load_s || !erase_pulse);
        end
    end
endmodule // pme_top

//--- verification/pme_top_assertions.sv
// Concurrent checks on the programming mode entry block
`timescale 1ns/1ns
module pme_top_checker #(
    parameter RESET_CYCLES = 200
) (
    input wire mclk,
    input wire arst_n,
    input wire por_n,
    input wire reset_pin_n,
    input wire serial_out,
    input wire serial_out_oe_n,
    input wire prog_mode,
    input wire normal_run,
    input wire erase_pulse,
    input wire psel,
    input wire penable,
    input wire [7:0] paddr,
    input wire pslverr
);
    // ****************
    // Sequence counter
    // ****************
    logic [19:0] hi_cnt;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Saturates so a long session never wraps back into the entry window
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) hi_cnt <= 20'h0_0000;
        else if (!(por_n && reset_pin_n)) hi_cnt <= 20'h0_0000;
        else if (hi_cnt < RESET_CYCLES + 16) hi_cnt <= hi_cnt + 20'h0_0001;
    end
    a_entry_after_seq: assert property (($rose(prog_mode) || $rose(normal_run)) |->
        hi_cnt >= RESET_CYCLES && hi_cnt <= RESET_CYCLES + 8) else $error("mode out of window");
    a_decided_in_time: assert property (hi_cnt == RESET_CYCLES + 8 |->
        prog_mode || normal_run) else $error("no mode after sequence");
    a_modes_exclusive: assert property (!(prog_mode && normal_run)) else $error("both modes");
    a_reset_clears: assert property ((!(por_n && reset_pin_n))[*5] |->
        !prog_mode && !normal_run) else $error("mode during reset");
    a_prog_sticky: assert property ((por_n && reset_pin_n)[*4] ##0 prog_mode |=>
        prog_mode) else $error("left programming mode");
    a_normal_sticky: assert property ((por_n && reset_pin_n)[*4] ##0 normal_run |=>
        normal_run) else $error("left normal run");
    a_oe_tracks: assert property (serial_out_oe_n == !prog_mode) else $error("oe wrong");
    a_out_quiet: assert property (!prog_mode && !$past(prog_mode) |-> !serial_out)
        else $error("serial out driven");
    a_erase_single: assert property (erase_pulse |-> prog_mode ##1 !erase_pulse)
        else $error("erase pulse wrong");
    a_normal_gated: assert property (psel && penable && normal_run &&
        (paddr == 8'h08 || paddr == 8'h0C) |-> pslverr) else $error("init reachable");
    c_prog: cover property ($rose(prog_mode));
    c_normal: cover property ($rose(normal_run));
    c_erase: cover property (erase_pulse);
    c_refused: cover property (psel && penable && pslverr);
endmodule // pme_top_checker
bind pme_top pme_top_checker #(.RESET_CYCLES(RESET_CYCLES)) u_chk (.mclk(mclk),
    .arst_n(arst_n), .por_n(por_n), .reset_pin_n(reset_pin_n), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .prog_mode(prog_mode), .normal_run(normal_run),
    .erase_pulse(erase_pulse), .psel(psel), .penable(penable), .paddr(paddr),
    .pslverr(pslverr));

//--- verification/pme_prog_model.sv
// Behavioural programmer that drives the opcode link
`timescale 1ns/1ns
module pme_prog_model (
    output logic link_clock,
    output logic link_load,
    output logic serial_in
);
    // Link clock parks low between frames, load held high
    initial begin
        link_clock = 1'b0;
        link_load = 1'b1;
        serial_in = 1'b0;
    end
    // MSB first, data set half a period before each rise, off the mclk phase
    task automatic send(input logic [31:0] bits, input int n);
        #7;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = bits[i];
            #160 link_clock = 1'b1;
            #160 link_clock = 1'b0;
        end
        // A released line shows the inverse so a stale bit is never reused
        serial_in = ~serial_in;
    endtask
endmodule // pme_prog_model

//--- verification/pme_top_test.sv
// Self-checking bench for the programming mode entry block
`timescale 1ns/1ns
`include "pme_defs.vh"
module pme_top_test;
    localparam int RC = 200;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic por_n = 1'b0;
    logic reset_pin_n = 1'b1;
    logic core_flags_wr = 1'b0;
    logic [7:0] nv_init1 = 8'h00;
    logic [7:0] core_flags_wdata = 8'h00;
    logic [6:0] core_flags_hw = 7'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] seed = 32'h0001_1326;
    logic [31:0] rd;
    logic er;
    logic erase_seen = 1'b0;
    int err_total = 0;
    int n_compared = 0;
    wire link_clock, link_load, serial_in, serial_out, serial_out_oe_n;
    wire prog_mode, normal_run, erase_pulse, pready, pslverr;
    wire [31:0] prdata;
    // ****************
    // Clock and parts
    // ****************
    always #20 mclk = ~mclk;
    pme_top #(.RESET_CYCLES(RC)) dut (.mclk(mclk), .arst_n(arst_n), .por_n(por_n),
        .reset_pin_n(reset_pin_n), .link_clock(link_clock), .link_load(link_load),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
        .nv_init1(nv_init1), .nv_init2(8'h00), .core_flags_wr(core_flags_wr),
        .core_flags_wdata(core_flags_wdata), .core_flags_hw(core_flags_hw),
        .prog_mode(prog_mode), .normal_run(normal_run), .erase_pulse(erase_pulse),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    pme_prog_model u_prog (.link_clock(link_clock), .link_load(link_load),
        .serial_in(serial_in));
    // Sticky capture, the pulse lasts one cycle only
    always @(posedge mclk) if (erase_pulse === 1'b1) erase_seen <= 1'b1;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Any ten-bit window of the stream equal to the entry pattern counts
    function automatic logic opcode_in(input logic [31:0] bits, input int n);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i + 10 <= n; i++) hit |= (bits[i +: 10] == `PME_ENTRY_OPCODE);
        return hit;
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // One APB transfer; the answer is taken at the edge where pready is high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Wait as long as the slave asks; only the watchdog ends a hang
        do @(posedge mclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic xe);
        apb(1'b0, a, 32'h0000_0000);
        check("pslverr", {31'h0, er}, {31'h0, xe});
        if (!xe) check("prdata", rd, exp);
    endtask
    // Reset by either source, shift a stream, then wait for the mode decision
    task automatic session(input logic por, input logic [31:0] bits, input int n, input logic hold);
        logic want;
        want = !hold && opcode_in(bits, n);
        @(posedge mclk);
        if (por) por_n <= 1'b0;
        else reset_pin_n <= 1'b0;
        repeat (10) @(posedge mclk);
        if (hold) u_prog.send(bits, n);
        @(posedge mclk);
        por_n <= 1'b1;
        reset_pin_n <= 1'b1;
        if (!hold) u_prog.send(bits, n);
        for (int i = 0; i < 2 * RC; i++) begin
            @(posedge mclk);
            if (prog_mode === 1'b1 || normal_run === 1'b1) break;
        end
        check("prog_mode", {31'h0, prog_mode}, {31'h0, want});
        check("normal_run", {31'h0, normal_run}, {31'h0, !want});
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        logic [31:0] junk;
        logic [7:0] fl;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        session(1'b1, `PME_ENTRY_OPCODE, 10, 1'b0);
        rchk(`PME_REG_STATUS, 32'h0000_0003, 1'b0);
        rchk(`PME_REG_INIT2, 32'h0000_0080, 1'b0);
        rchk(`PME_REG_INIT1, 32'h0000_0000, 1'b0);
        check("serial_out", {31'h0, serial_out}, 32'h0000_0001);
        check("serial_out_oe_n", {31'h0, serial_out_oe_n}, 32'h0000_0000);
        apb(1'b1, `PME_REG_INIT2, 32'h0000_005A);
        rchk(`PME_REG_INIT2, 32'h0000_005A, 1'b0);
        u_prog.send(rnd(), 12);
        repeat (2 * RC) @(posedge mclk);
        check("prog_mode", {31'h0, prog_mode}, 32'h0000_0001);
        for (int k = 0; k < 3; k++) session(1'b0, rnd(), 12 + k, 1'b0);
        session(1'b0, `PME_ENTRY_OPCODE, 10, 1'b1);
        rchk(`PME_REG_INIT1, 32'h0000_0000, 1'b1);
        rchk(8'h14, 32'h0000_0000, 1'b1);
        junk = rnd();
        fl = junk[7:0];
        @(posedge mclk);
        core_flags_hw <= fl[6:0];
        core_flags_wdata <= ~fl;
        core_flags_wr <= 1'b1;
        @(posedge mclk);
        core_flags_wr <= 1'b0;
        rchk(`PME_REG_FLAGS, {24'h00_0000, ~fl[7], fl[6:0]}, 1'b0);
        nv_init1 <= 8'h03;
        junk = rnd();
        session(1'b0, {junk[6:0], `PME_ENTRY_OPCODE}, 17, 1'b0);
        rchk(`PME_REG_INIT1, 32'h0000_0000, 1'b1);
        apb(1'b1, `PME_REG_INIT2, 32'h0000_0011);
        apb(1'b1, `PME_REG_CONTROL, 32'h0000_0001);
        repeat (4) @(posedge mclk);
        check("erase_pulse", {31'h0, erase_seen}, 32'h0000_0001);
        rchk(`PME_REG_INIT1, 32'h0000_0000, 1'b0);
        rchk(`PME_REG_INIT2, 32'h0000_0080, 1'b0);
        give_verdict();
    end
    // Whole run needs some two thousand cycles; this bound is generous
    initial begin
        #(40 * 30000);
        err_total++;
        give_verdict();
    end
endmodule // pme_top_test
